/* hdl/lpi_codec_port.sv */
// One port's codec serial interface: bus capture and bit shifting
module lpi_codec_port
    import lpi_pkg::*;
(
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    // Bus side
    input  wire logic [NBUS-1:0]       cap_en,
    input  wire logic [NBUS-1:0][7:0]  bus_data,
    input  wire logic                  bus_sel,
    output logic      [7:0]            tx_byte,
    // Codec side
    input  wire logic                  frame_ld,
    input  wire logic                  bit_tick,
    input  wire logic                  sd_in,
    output logic                       sd_out
);

    logic [NBUS-1:0][7:0] hold;
    logic [NBUS-1:0][7:0] shf;
    logic [7:0]           col;
    logic [3:0]           bit_cnt;

    // Parallel capture from the selected bus slot
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hold <= '0;
        end else begin
            for (int b = 0; b < NBUS; b++) begin
                if (cap_en[b]) begin
                    hold[b] <= bus_data[b];
                end
            end
        end
    end

    // Both shifters load at the frame, shift on falling sclk
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            shf     <= '0;
            bit_cnt <= 4'h8;
        end else if (frame_ld) begin
            shf     <= hold;
            bit_cnt <= 4'h0;
        end else if (bit_tick && !bit_cnt[3]) begin
            for (int b = 0; b < NBUS; b++) begin
                shf[b] <= {shf[b][6:0], 1'b0};
            end
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    // Output bit from the shifter named by the bus select
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sd_out <= 1'b0;
        end else begin
            sd_out <= shf[bus_sel][7];
        end
    end

    // Collect codec bits; byte handed over after the eighth
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            col     <= '0;
            tx_byte <= '0;
        end else if (bit_tick && !bit_cnt[3]) begin
            col <= {col[6:0], sd_in};
            if (bit_cnt == 4'h7) begin
                tx_byte <= {col[6:0], sd_in};
            end
        end
    end

endmodule

/* hdl/lpi_diag_uart.sv */
// Transmit-only asynchronous diagnostic serial port, 8N1
module lpi_diag_uart
    import lpi_pkg::*;
#(
    parameter int DIV = DIAG_DIV
)
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Byte in
    input  wire logic       send,
    input  wire logic [7:0] data,
    output logic            busy,
    // Line
    output logic            txd
);

    localparam int CW = $clog2(DIV);

    lpi_uart_st_t  st;
    logic [CW-1:0] cnt;
    logic [7:0]    sh;
    logic [2:0]    nbit;
    logic          bit_end;

    assign bit_end = (cnt == CW'(DIV - 1));

    // Bit timer, restarted when a byte is taken
    always_ff @(posedge mclk) begin
        if (!rst_n || st == U_IDLE || bit_end) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    // Framing sequence; a send while busy is dropped
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st   <= U_IDLE;
            sh   <= '0;
            nbit <= '0;
            txd  <= 1'b1;
            busy <= 1'b0;
        end else begin
            unique case (st)
                U_IDLE: begin
                    if (send) begin
                        sh   <= data;
                        st   <= U_START;
                        txd  <= 1'b0;
                        busy <= 1'b1;
                    end
                end
                U_START: begin
                    if (bit_end) begin
                        st   <= U_DATA;
                        txd  <= sh[0];
                        nbit <= '0;
                    end
                end
                U_DATA: begin
                    if (bit_end) begin
                        sh   <= {1'b0, sh[7:1]};
                        nbit <= nbit + 3'h1;
                        txd  <= (nbit == 3'h7) ? 1'b1 : sh[1];
                        st   <= (nbit == 3'h7) ? U_STOP : U_DATA;
                    end
                end
                U_STOP: begin
                    if (bit_end) begin
                        st   <= U_IDLE;
                        busy <= 1'b0;
                    end
                end
            endcase
        end
    end

endmodule

/* hdl/lpi_line_card.sv */
// Top of the eight-port PCM line interface digital logic
module lpi_line_card
    import lpi_pkg::*;
#(
    parameter int DIAG_DIVIDER = DIAG_DIV
)
(
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    // Register port
    input  wire logic [ADDR_W-1:0]      reg_addr,
    input  wire logic [DATA_W-1:0]      reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [DATA_W-1:0]      reg_rdata,
    // PCM timeslot busses
    input  wire logic                   pcm_frame,
    input  wire logic                   pcm_slot_tick,
    input  wire logic [NBUS-1:0][7:0]   pcm_rx_data,
    output logic      [7:0]             pcm_tx_data,
    output logic      [NBUS-1:0]        pcm_tx_oe,
    // Codecs
    output logic                        codec_sclk,
    output logic                        codec_fs,
    output logic                        codec_law,
    output logic                        codec_clk_sel,
    output logic      [NPORT-1:0]       codec_sd_out,
    input  wire logic [NPORT-1:0]       codec_sd_in,
    // Line circuits
    input  wire logic [NPORT-1:0]       hook_off,
    input  wire logic [NPORT-1:0][3:0]  dtmf_code,
    input  wire logic [NPORT-1:0]       dtmf_strobe,
    output logic      [NPORT-1:0]       ring_relay,
    // Front panel and diagnostics
    output logic      [2:0]             led,
    output logic                        diag_txd
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [2:0]             ctrl;
    lpi_sel_t               tx_cfg;
    logic [NPORT-1:0]       ring_req;
    logic [NPORT-1:0]       ring_dis;
    logic [NPORT-1:0]       ring_trip;
    logic [NPORT-1:0]       hook_seen;
    logic [NPORT-1:0]       hook_chg;
    logic [NPORT-1:0]       dig_pend;
    logic [NPORT-1:0]       dig_evt;
    logic [NPORT-1:0][3:0]  dig_latch;
    logic [NPORT-1:0][3:0]  dig_rep;
    logic [2:0]             scan_idx;
    lpi_sel_t [NPORT-1:0]   listen_new;
    lpi_sel_t [NPORT-1:0]   listen_act;
    logic [7:0]             slot_cnt;
    logic [7:0]             cur_slot;
    logic                   frame_tick;
    logic [31:0]            nco_acc;
    logic                   nco_carry;
    logic                   bit_tick;
    logic [NPORT-1:0][7:0]  port_tx;
    logic [NPORT-1:0]       port_sel;
    logic                   diag_busy;
    logic                   diag_send;
    logic [NPORT-1:0]       scan_hit;
    logic [NPORT-1:0]       chg_set;
    logic [NPORT-1:0]       evt_set;
    logic [NPORT-1:0]       chg_clr;
    logic [NPORT-1:0]       evt_clr;
    logic [DATA_W-1:0]      next_rdata;

    // Register write decode
    function automatic logic wr_hit(input logic [5:0] a);
        return reg_wr && (reg_addr == a);
    endfunction

    // ------------------------------------------------------------
    // Frame and slot timing
    // ------------------------------------------------------------

    // Slot number valid in the tick cycle; frame pulse marks slot 0
    assign frame_tick = pcm_frame && pcm_slot_tick;
    assign cur_slot   = pcm_frame ? 8'h00 : slot_cnt + 8'h01;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            slot_cnt <= 8'hFF;
        end else if (pcm_slot_tick) begin
            slot_cnt <= cur_slot;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------

    // Common codec clock, law and transmit enable
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl <= CTRL_RST;
        end else if (wr_hit(REG_CTRL)) begin
            ctrl <= reg_wdata[2:0];
        end
    end

    // Card's own block base slot and transmit bus
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tx_cfg <= '0;
        end else if (wr_hit(REG_TXCFG)) begin
            tx_cfg <= reg_wdata[SEL_BUS_BIT:0];
        end
    end

    // Indicator register: red, yellow, green on bits 2..0
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            led <= LED_RST;
        end else if (wr_hit(REG_LED)) begin
            led <= reg_wdata[2:0];
        end
    end

    // Listen selections: written any time, used from next frame
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            listen_new <= '0;
            listen_act <= '0;
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                if (wr_hit(REG_LISTEN + 6'(p))) begin
                    listen_new[p] <= reg_wdata[SEL_BUS_BIT:0];
                end
            end
            if (frame_tick) begin
                listen_act <= listen_new;
            end
        end
    end

    // ------------------------------------------------------------
    // Ring relays
    // ------------------------------------------------------------

    // Trip when a ringing line answers
    assign ring_trip = ring_relay & hook_off;

    // Trip beats a same-cycle write so ringing cannot restart
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ring_req <= '0;
            ring_dis <= '0;
        end else begin
            if (wr_hit(REG_RING)) begin
                ring_req <= reg_wdata[NPORT-1:0] & ~ring_trip;
            end else begin
                ring_req <= ring_req & ~ring_trip;
            end
            if (wr_hit(REG_REARM)) begin
                ring_dis <= (ring_dis & ~reg_wdata[NPORT-1:0])
                            | ring_trip;
            end else begin
                ring_dis <= ring_dis | ring_trip;
            end
        end
    end

    // Relay drive; a line off hook at the previous clock gets no ring voltage
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ring_relay <= '0;
        end else begin
            ring_relay <= ring_req & ~ring_dis & ~hook_off;
        end
    end

    // ------------------------------------------------------------
    // Tone digits and event scanning
    // ------------------------------------------------------------

    // Every four-bit code is a legal keypad symbol, none dropped
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dig_latch <= '0;
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                if (dtmf_strobe[p]) begin
                    dig_latch[p] <= dtmf_code[p];
                end
            end
        end
    end

    // One port examined per cycle, round robin
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            scan_idx <= '0;
        end else begin
            scan_idx <= scan_idx + 3'h1;
        end
    end

    // Per-port scan terms: hook changes and waiting digits
    always_comb begin
        scan_hit = '0;
        scan_hit[scan_idx] = 1'b1;
        chg_set  = scan_hit & (hook_off ^ hook_seen);
        evt_set  = scan_hit & dig_pend;
    end

    // A new strobe in the scan cycle keeps its pending flag
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hook_seen <= '0;
            dig_pend  <= '0;
            dig_rep   <= '0;
        end else begin
            hook_seen <= hook_seen ^ chg_set;
            dig_pend  <= (dig_pend & ~evt_set) | dtmf_strobe;
            for (int p = 0; p < NPORT; p++) begin
                if (evt_set[p]) begin
                    dig_rep[p] <= dig_latch[p];
                end
            end
        end
    end

    // Poll read clears only what it reported; new sets win
    assign chg_clr = (reg_rd && reg_addr == REG_EVENT) ? hook_chg : '0;
    assign evt_clr = (reg_rd && reg_addr == REG_EVENT) ? dig_evt : '0;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hook_chg <= '0;
            dig_evt  <= '0;
        end else begin
            hook_chg <= (hook_chg & ~chg_clr) | chg_set;
            dig_evt  <= (dig_evt & ~evt_clr) | evt_set;
        end
    end

    // ------------------------------------------------------------
    // Codec clocking
    // ------------------------------------------------------------

    // Phase accumulator: 250 MHz does not divide to either rate
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            nco_acc   <= '0;
            nco_carry <= 1'b0;
        end else begin
            {nco_carry, nco_acc} <= {1'b0, nco_acc}
                + {1'b0, (ctrl[CTRL_CLK_BIT] ? NCO_INC_E1
                                             : NCO_INC_T1)};
        end
    end

    // Bit clock, frame sync and common codec settings
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            codec_sclk    <= 1'b0;
            codec_fs      <= 1'b0;
            codec_law     <= 1'b0;
            codec_clk_sel <= 1'b0;
        end else begin
            codec_sclk    <= codec_sclk ^ nco_carry;
            codec_fs      <= frame_tick;
            codec_law     <= ctrl[CTRL_LAW_BIT];
            codec_clk_sel <= ctrl[CTRL_CLK_BIT];
        end
    end

    // Shift on the falling edge so codecs sample mid-bit
    assign bit_tick = nco_carry && codec_sclk;

    // ------------------------------------------------------------
    // Per-port codec interfaces
    // ------------------------------------------------------------
    for (genvar p = 0; p < NPORT; p++) begin : g_port
        logic [NBUS-1:0] cap;
        // Either bus, same rule: slot and bus both match
        always_comb begin
            for (int b = 0; b < NBUS; b++) begin
                cap[b] = pcm_slot_tick
                    && cur_slot == listen_act[p].slot
                    && listen_act[p].bus == 1'(b);
            end
        end
        assign port_sel[p] = listen_act[p].bus;

        lpi_codec_port u_port (
            .mclk     (mclk),
            .rst_n    (rst_n),
            .cap_en   (cap),
            .bus_data (pcm_rx_data),
            .bus_sel  (port_sel[p]),
            .tx_byte  (port_tx[p]),
            .frame_ld (frame_tick),
            .bit_tick (bit_tick),
            .sd_in    (codec_sd_in[p]),
            .sd_out   (codec_sd_out[p])
        );
    end

    // ------------------------------------------------------------
    // Transmit onto the PCM bus
    // ------------------------------------------------------------

    // Port k owns slot base+k; its slot and bus also name it
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pcm_tx_data <= '0;
            pcm_tx_oe   <= '0;
        end else if (pcm_slot_tick) begin
            pcm_tx_oe <= '0;
            if (ctrl[CTRL_TXEN_BIT]
                && (cur_slot - tx_cfg.slot) < 8'(NPORT)) begin
                pcm_tx_data <= port_tx[3'(cur_slot - tx_cfg.slot)];
                pcm_tx_oe[tx_cfg.bus] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Diagnostic serial port
    // ------------------------------------------------------------
    assign diag_send = wr_hit(REG_DIAG);

    lpi_diag_uart #(
        .DIV (DIAG_DIVIDER)
    ) u_diag (
        .mclk  (mclk),
        .rst_n (rst_n),
        .send  (diag_send),
        .data  (reg_wdata[7:0]),
        .busy  (diag_busy),
        .txd   (diag_txd)
    );

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------

    // Read mux; unmapped offsets return zero
    always_comb begin
        next_rdata = '0;
        unique case (reg_addr)
            REG_CTRL:   next_rdata = {13'h0000, ctrl};
            REG_TXCFG:  next_rdata = {7'h00, tx_cfg};
            REG_LED:    next_rdata = {13'h0000, led};
            REG_RING:   next_rdata = {8'h00, ring_req};
            REG_REARM:  next_rdata = {8'h00, ring_dis};
            REG_HOOK:   next_rdata = {8'h00, hook_off};
            REG_EVENT:  next_rdata = {dig_evt, hook_chg};
            REG_DIG_LO: next_rdata = {dig_rep[3], dig_rep[2],
                                      dig_rep[1], dig_rep[0]};
            REG_DIG_HI: next_rdata = {dig_rep[7], dig_rep[6],
                                      dig_rep[5], dig_rep[4]};
            REG_DIAG:   next_rdata = {15'h0000, diag_busy};
            default: begin
                if (reg_addr[5:3] == REG_LISTEN[5:3]) begin
                    next_rdata = {7'h00, listen_new[reg_addr[2:0]]};
                end
            end
        endcase
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata <= RDATA_RST;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : RDATA_RST;
        end
    end

endmodule

/* inc/lpi_pkg.sv */
// Package of constants and types for the eight-port PCM line interface
package lpi_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NPORT  = 8;
    localparam int NBUS   = 2;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [5:0] REG_CTRL   = 6'h00;
    localparam logic [5:0] REG_TXCFG  = 6'h01;
    localparam logic [5:0] REG_LED    = 6'h02;
    localparam logic [5:0] REG_RING   = 6'h03;
    localparam logic [5:0] REG_REARM  = 6'h04;
    localparam logic [5:0] REG_HOOK   = 6'h05;
    localparam logic [5:0] REG_EVENT  = 6'h06;
    localparam logic [5:0] REG_DIG_LO = 6'h07;
    localparam logic [5:0] REG_DIG_HI = 6'h08;
    localparam logic [5:0] REG_DIAG   = 6'h09;
    localparam logic [5:0] REG_LISTEN = 6'h10;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_CLK_BIT  = 0;
    localparam int CTRL_LAW_BIT  = 1;
    localparam int CTRL_TXEN_BIT = 2;
    localparam int SEL_BUS_BIT   = 8;
    localparam logic [2:0]  CTRL_RST  = 3'h0;
    localparam logic [2:0]  LED_RST   = 3'h0;
    localparam logic [15:0] RDATA_RST = 16'h0000;

    // ------------------------------------------------------------
    // Keypad symbol codes from the tone detectors
    // ------------------------------------------------------------
    localparam logic [3:0] SYM_A    = 4'hA;
    localparam logic [3:0] SYM_STAR = 4'hE;
    localparam logic [3:0] SYM_HASH = 4'hF;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint MCLK_HZ    = 250000000;
    localparam longint CODEC_HZ_T1 = 1544000;
    localparam longint CODEC_HZ_E1 = 2048000;
    localparam int     DIAG_BAUD  = 9600;
    localparam int     DIAG_DIV   = int'(MCLK_HZ / DIAG_BAUD);
    // Phase steps give twice the codec rate; sclk toggles on carry
    localparam logic [31:0] NCO_INC_T1 =
        32'((CODEC_HZ_T1 * 2 * 64'h1_0000_0000) / MCLK_HZ);
    localparam logic [31:0] NCO_INC_E1 =
        32'((CODEC_HZ_E1 * 2 * 64'h1_0000_0000) / MCLK_HZ);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       bus;
        logic [7:0] slot;
    } lpi_sel_t;

    typedef enum logic [3:0] {
        U_IDLE  = 4'b0001,
        U_START = 4'b0010,
        U_DATA  = 4'b0100,
        U_STOP  = 4'b1000
    } lpi_uart_st_t;

endpackage

/* sim/lpi_line_card_chk.sv */
// Port assertions for the line card top
module lpi_line_card_chk
    import lpi_pkg::*;
(
    // Clock, reset, register port
    input wire logic                 mclk,
    input wire logic                 rst_n,
    input wire logic [ADDR_W-1:0]    reg_addr,
    input wire logic [DATA_W-1:0]    reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [DATA_W-1:0]    reg_rdata,
    // Bus, codec and line side
    input wire logic                 pcm_frame,
    input wire logic                 pcm_slot_tick,
    input wire logic [7:0]           pcm_tx_data,
    input wire logic [NBUS-1:0]      pcm_tx_oe,
    input wire logic                 codec_fs,
    input wire logic [NPORT-1:0]     hook_off,
    input wire logic [NPORT-1:0]     ring_relay,
    input wire logic [2:0]           led
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Slot-zero tick, then a one-clock sync
    sequence frame_tk;
        pcm_frame && pcm_slot_tick;
    endsequence
    sequence fs_pulse;
        codec_fs ##1 !codec_fs;
    endsequence
    chk_fs_pulse:
    assert property (frame_tk |=> fs_pulse) else $error("no fs");
    chk_fs_cause:
    assert property (codec_fs |-> $past(pcm_frame) && $past(pcm_slot_tick))
        else $error("stray fs");
    chk_rdata_idle:
    assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("rdata not idle");
    chk_oe_single:
    assert property ($onehot0(pcm_tx_oe)) else $error("two busses");
    chk_oe_rise:
    assert property ($rose(|pcm_tx_oe) |-> $past(pcm_slot_tick))
        else $error("oe off tick");
    chk_tx_hold:
    assert property (!pcm_slot_tick |=> $stable(pcm_tx_oe)
        && $stable(pcm_tx_data)) else $error("tx moved");
    chk_ring_trip:
    assert property (|(ring_relay & hook_off) |->
        ##[1:3] (ring_relay & hook_off) == 8'h00) else $error("no trip");
    chk_led_write:
    assert property (reg_wr && reg_addr == REG_LED |=>
        led == $past(reg_wdata[2:0])) else $error("led");
endmodule
bind lpi_line_card lpi_line_card_chk u_chk (
    .mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .pcm_frame, .pcm_slot_tick, .pcm_tx_data, .pcm_tx_oe, .codec_fs,
    .hook_off, .ring_relay, .led
);

/* sim/lpi_line_card_test.sv */
// Self-checking bench for the line card
module lpi_line_card_test
    import lpi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
    logic [ADDR_W-1:0]      reg_addr = '0;
    logic [DATA_W-1:0]      reg_wdata = '0, reg_rdata;
    logic                   pcm_frame, pcm_slot_tick, law, csel, txd;
    logic                   chk_on = 0, txb = 0;
    logic [NBUS-1:0][7:0]   pcm_rx_data;
    logic [NBUS-1:0]        pcm_tx_oe;
    logic [7:0]             pcm_tx_data, slot, ring_relay, sd;
    logic [7:0]             hook_off = '0, dtmf_strobe = '0;
    logic [NPORT-1:0][3:0]  dtmf_code = '0;
    logic [2:0]             led;
    logic [1:0]             ph;
    int                     err_total = 0, n_tests = 0, cyc = 0;
    always #2 mclk = ~mclk;
    lpi_line_card #(.DIAG_DIVIDER(8)) DUT (
        .mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .pcm_frame, .pcm_slot_tick, .pcm_rx_data, .pcm_tx_data, .pcm_tx_oe,
        .codec_sclk(), .codec_fs(), .codec_law(law), .codec_clk_sel(csel),
        .codec_sd_out(sd), .codec_sd_in(sd), .hook_off, .dtmf_code,
        .dtmf_strobe, .ring_relay, .led, .diag_txd(txd)
    );
    lpi_pcm_model PCM (.mclk, .rst_n, .pcm_frame, .pcm_slot_tick,
        .pcm_rx_data, .slot, .ph);
    task automatic chk(input logic [15:0] g, e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [5:0] a, input logic [15:0] e);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        chk(reg_rdata, e);
    endtask
    task automatic results;
        $display("Compares %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Slot owner check mid-slot, block wraps past 255; codecs looped
    // back, so port 2 (slot FE) returns its listened byte, others 00
    always @(negedge mclk) begin
        cyc++;
        if (chk_on && ph == 2'd2) chk({6'h00, pcm_tx_oe, pcm_tx_data},
            {6'h00, ((slot - 8'hFC) < 8'h08) ? (txb ? 2'b10 : 2'b01)
            : 2'b00, (slot == 8'hFE) ? 8'hCA : 8'h00});
        if (cyc == 8000) begin
            err_total++;
            results;
        end
    end
    initial begin
        w(2);
        rst_n <= 1'b1;
        rdc(6'h3F, 16'h0000);
        wr(REG_CTRL, 16'h0007);
        w(1);
        @(negedge mclk);
        chk({14'h0000, law, csel}, 16'h0003);
        wr(REG_LED, 16'h0005);
        @(negedge mclk);
        chk({13'h0000, led}, 16'h0005);
        wr(REG_LISTEN + 6'h02, 16'h0135);
        rdc(REG_LISTEN + 6'h02, 16'h0135);
        w(2500);
        for (int b = 0; b < 2; b++) begin
            txb = b[0];
            wr(REG_TXCFG, {7'h00, b[0], 8'hFC});
            w(40);
            chk_on = 1'b1;
            w(1100);
            chk_on = 1'b0;
        end
        wr(REG_RING, 16'h0001);
        w(4);
        chk({8'h00, ring_relay}, 16'h0001);
        hook_off <= 8'h01;
        w(14);
        chk({8'h00, ring_relay}, 16'h0000);
        rdc(REG_HOOK, 16'h0001);
        rdc(REG_EVENT, 16'h0001);
        w(1);
        hook_off <= 8'h00;
        w(14);
        chk({8'h00, ring_relay}, 16'h0000);
        rdc(REG_EVENT, 16'h0001);
        rdc(REG_EVENT, 16'h0000);
        rdc(REG_REARM, 16'h0001);
        w(1);
        dtmf_code[3] <= SYM_HASH;
        dtmf_strobe  <= 8'h08;
        w(1);
        dtmf_strobe <= 8'h00;
        w(12);
        rdc(REG_EVENT, 16'h0800);
        rdc(REG_DIG_LO, 16'hF000);
        wr(REG_DIAG, 16'h0055);
        rdc(REG_DIAG, 16'h0001);
        chk({15'h0000, txd}, 16'h0000);
        results;
    end
endmodule

/* sim/lpi_pcm_model.sv */
// Timeslot bus model: ticks, frame marks, bus bytes
module lpi_pcm_model
    import lpi_pkg::*;
(
    input  wire logic               mclk,
    input  wire logic               rst_n,
    output logic                    pcm_frame,
    output logic                    pcm_slot_tick,
    output logic [NBUS-1:0][7:0]    pcm_rx_data,
    output logic [7:0]              slot,
    output logic [1:0]              ph
);
    timeunit 1ns;
    timeprecision 1ps;
    // One slot per four clocks; idle bytes toggle so none look held
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            {ph, pcm_frame, pcm_slot_tick, pcm_rx_data} <= '0;
            slot <= 8'hFF;
        end else begin
            ph            <= ph + 2'd1;
            pcm_slot_tick <= &ph;
            pcm_frame     <= &ph && &slot;
            if (&ph) begin
                slot        <= slot + 8'h01;
                // Bus 0 byte carries the number of the slot now ticking, bus 1 its complement
                pcm_rx_data <= {~(slot + 8'h01), slot + 8'h01};
            end else begin
                pcm_rx_data <= ~pcm_rx_data;
            end
        end
    end
endmodule
